// ==== design/spi_frame_consts.svh ====
`ifndef SPI_FRAME_CONSTS_SVH
`define SPI_FRAME_CONSTS_SVH

// Frame lengths in serial clocks
`define LEN_16 6'd16
`define LEN_17 6'd17
`define LEN_20 6'd20
`define LEN_21 6'd21

// Register addresses
`define NO_OP_ADDR 6'h00
`define NO_OP_ADDR_LO 6'h01
`define NO_OP_PAIR 5'h00
`define WARN_PAIR 5'h13
`define WARN_ADDR_HI 6'h26
`define WARN_ADDR_LO 6'h27

// Warning word layout
`define WARN_FIXED 4'hB
`define IFLAG_POS 11
`define CRC_FLAG_POS 10
`define IFLAG_BYTE_POS 3
`define CRC_BYTE_POS 2

// Stray clock window after chip select rises
`define STRAY_WINDOW_NS 70
`define REF_CLK_PERIOD_NS 50

// Checksum
`define CRC_SEED 4'hF
`define CRC_POLY 4'h3

// Reset values
`define RESP_RESET 16'h0000
`define BYTE_RESET 8'h00

`endif

// ==== design/spi_frame_pkg.sv ====
package spi_frame_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SELECTED = 4'b0010,
    ST_WINDOW = 4'b0100,
    ST_COMMIT = 4'b1000
  } eval_state_type;

  typedef logic [5:0] edge_count_type;

  function automatic edge_count_type bin2gray(input edge_count_type b);
    return b ^ (b >> 1);
  endfunction

  function automatic edge_count_type gray2bin(input edge_count_type g);
    edge_count_type b;
    b = g;
    for (int i = 4; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// ==== design/spi_link_if.sv ====
`timescale 1ns/100ps
`default_nettype none

interface spi_link_if;
  logic [20:0] rx_bits;
  logic [5:0] sel_gray;
  logic [5:0] stray_gray;
  logic [15:0] tx_word;
  logic [3:0] tx_crc;
  logic [5:0] base_sel;
  logic [5:0] base_stray;
  logic corrupt;

  modport link (
    output rx_bits, sel_gray, stray_gray,
    input tx_word, tx_crc, base_sel, base_stray, corrupt
  );
  modport core (
    input rx_bits, sel_gray, stray_gray,
    output tx_word, tx_crc, base_sel, base_stray, corrupt
  );
endinterface

`default_nettype wire

// ==== design/level_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_ref_clk,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge i_ref_clk) begin
    meta_reg <= i_async;
    sync_reg <= meta_reg;
  end

  assign o_sync = sync_reg;
endmodule // level_sync

`default_nettype wire

// ==== design/spi_link_port.sv ====
`timescale 1ns/100ps
`default_nettype none

// Chip select and data are timed by the master against the serial clock,
// so they are sampled directly on its edges.
module spi_link_port (
  input wire logic i_spi_sclk,
  input wire logic i_sys_rst,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  spi_link_if.link lnk
);
  logic rst_meta_reg;
  logic rst_reg;
  spi_frame_pkg::edge_count_type sel_reg, sel_next;
  spi_frame_pkg::edge_count_type stray_reg, stray_next;
  logic [20:0] rx_reg, rx_next;
  spi_frame_pkg::edge_count_type sel_gray_reg, stray_gray_reg;
  spi_frame_pkg::edge_count_type bit_idx;
  logic [20:0] tx_seq;
  logic miso_reg, miso_next;

  always_ff @(posedge i_spi_sclk) begin
    rst_meta_reg <= i_sys_rst;
    rst_reg <= rst_meta_reg;
  end

  always_comb begin
    sel_next = sel_reg;
    stray_next = stray_reg;
    rx_next = rx_reg;
    if (rst_reg) begin
      sel_next = '0;
      stray_next = '0;
      rx_next = '0;
    end else if (!i_spi_cs_n) begin
      sel_next = sel_reg + 6'h01;
      rx_next = {rx_reg[19:0], i_spi_mosi};
    end else begin
      // Deselected edges keep being counted
      stray_next = stray_reg + 6'h01;
    end
  end

  always_ff @(posedge i_spi_sclk) begin
    sel_reg <= sel_next;
    stray_reg <= stray_next;
    rx_reg <= rx_next;
    sel_gray_reg <= spi_frame_pkg::bin2gray(sel_next);
    stray_gray_reg <= spi_frame_pkg::bin2gray(stray_next);
  end

  // Short frames keep advancing the bit pointer on stray edges, which
  // misaligns the next response
  always_comb begin
    tx_seq = {lnk.tx_word, lnk.tx_crc, lnk.tx_crc[3]};
    bit_idx = sel_reg - lnk.base_sel;
    if (lnk.corrupt) begin
      bit_idx = bit_idx + (stray_reg - lnk.base_stray);
    end
    miso_next = 1'b0;
    if (rst_reg) begin
      miso_next = 1'b0;
    end else if (bit_idx < 6'd21) begin
      miso_next = tx_seq[5'(6'd20 - bit_idx)];
    end
  end

  always_ff @(negedge i_spi_sclk) begin
    miso_reg <= miso_next;
  end

  assign o_spi_miso = miso_reg;
  assign lnk.rx_bits = rx_reg;
  assign lnk.sel_gray = sel_gray_reg;
  assign lnk.stray_gray = stray_gray_reg;
endmodule // spi_link_port

`default_nettype wire

// ==== design/spi_frame_error_detect.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "spi_frame_consts.svh"


module spi_frame_error_detect (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  input wire logic i_seventeen_bit_frame_select,
  input wire logic i_crc_check_enable,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  output logic o_interface_error_flag,
  output logic o_crc_error_flag,
  output logic o_write_done,
  output logic o_read_done
);

  // Longest time, so it rounds down, but never below one cycle
  localparam int STRAY_WIN_RAW = `STRAY_WINDOW_NS / `REF_CLK_PERIOD_NS;
  localparam int STRAY_WIN_CYC = (STRAY_WIN_RAW < 1) ? 1 : STRAY_WIN_RAW;
  localparam logic [2:0] STRAY_WIN_LAST = 3'(STRAY_WIN_CYC - 1);

  spi_link_if lnk ();

  spi_link_port u_link (
    .i_spi_sclk(i_spi_sclk),
    .i_sys_rst(i_sys_rst),
    .i_spi_cs_n(i_spi_cs_n),
    .i_spi_mosi(i_spi_mosi),
    .o_spi_miso(o_spi_miso),
    .lnk(lnk.link)
  );

  logic [12:0] sync_out;
  logic cfg_frame17_s, cfg_crc_en_s;

  level_sync #(.WIDTH(13)) u_link_sync (
    .i_ref_clk(i_ref_clk),
    .i_async({i_spi_cs_n, lnk.sel_gray, lnk.stray_gray}),
    .o_sync(sync_out)
  );

  level_sync #(.WIDTH(2)) u_cfg_sync (
    .i_ref_clk(i_ref_clk),
    .i_async({i_seventeen_bit_frame_select, i_crc_check_enable}),
    .o_sync({cfg_frame17_s, cfg_crc_en_s})
  );

  function automatic logic [3:0] crc4(input logic [15:0] data);
    logic [3:0] c;
    logic fb;
    c = `CRC_SEED;
    for (int i = 15; i >= 0; i--) begin
      fb = c[3] ^ data[i];
      c = {c[2:0], 1'b0};
      if (fb) begin
        c = c ^ `CRC_POLY;
      end
    end
    return c;
  endfunction

  function automatic logic len_ok(input logic [5:0] len, input logic allow17);
    return (len == `LEN_16) || (len == `LEN_17 && allow17) ||
           (len == `LEN_20) || (len == `LEN_21);
  endfunction

  // Decide whether deselected clock pulses corrupt the count
  function automatic logic stray_flag(
    input logic [5:0] prev_len,
    input logic allow17,
    input logic [5:0] pulses
  );
    logic f;
    f = 1'b0;
    if (prev_len == `LEN_21) begin
      f = 1'b0;
    end else if (prev_len == `LEN_20) begin
      // A pulse pair re-aligns the counter, so only odd counts are caught
      f = pulses[0];
    end else if (prev_len == `LEN_17) begin
      f = (pulses != 6'h00);
    end else if (allow17) begin
      f = (pulses >= 6'h02);
    end else begin
      f = (pulses != 6'h00);
    end
    return f;
  endfunction

  function automatic logic is_hidden(input logic [5:0] addr);
    return (addr == `NO_OP_ADDR) || (addr == `NO_OP_ADDR_LO) ||
           (addr == `WARN_ADDR_HI) || (addr == `WARN_ADDR_LO);
  endfunction

  spi_frame_pkg::eval_state_type state_reg, state_next;
  logic [2:0] win_reg, win_next;
  logic [5:0] sel_start_reg, sel_start_next;
  logic [5:0] stray_start_reg, stray_start_next;
  logic [5:0] stray_base_reg, stray_base_next;
  logic [5:0] prev_len_reg, prev_len_next;
  logic desel_err_reg, desel_err_next;
  logic armed_reg, armed_next;
  logic iflag_reg, iflag_next;
  logic crc_reg, crc_next;
  logic [15:0] resp_reg, resp_next;
  logic [3:0] resp_crc_reg, resp_crc_next;
  logic [5:0] base_sel_reg, base_sel_next;
  logic [5:0] base_stray_reg, base_stray_next;
  logic corrupt_reg, corrupt_next;
  logic miso_oe_reg, miso_oe_next;
  logic wr_done_reg, wr_done_next;
  logic rd_done_reg, rd_done_next;
  logic [7:0] mem_reg [64];
  logic [7:0] mem_next [64];

  logic cs_s;
  logic [5:0] sel_now, stray_now, frame_len;
  logic [15:0] frame_top, rd_word;
  logic [3:0] frame_crc;
  logic bad_len, msb_one, crc_bad, early_stray, frame_err, accept;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic iflag_set, iflag_clr, crc_set, crc_clr;

  always_comb begin
    cs_s = sync_out[12];
    sel_now = spi_frame_pkg::gray2bin(sync_out[11:6]);
    stray_now = spi_frame_pkg::gray2bin(sync_out[5:0]);
    // Link bits are static here: chip select is high and has been synced
    frame_len = sel_now - sel_start_reg;
    frame_top = lnk.rx_bits[15:0];
    frame_crc = 4'h0;
    if (frame_len == `LEN_17) begin
      frame_top = lnk.rx_bits[16:1];
    end else if (frame_len == `LEN_20) begin
      frame_top = lnk.rx_bits[19:4];
      frame_crc = lnk.rx_bits[3:0];
    end else if (frame_len == `LEN_21) begin
      // Trailing zero shifts the 20-bit layout by one place
      frame_top = lnk.rx_bits[20:5];
      frame_crc = lnk.rx_bits[4:1];
    end
    bad_len = !len_ok(frame_len, cfg_frame17_s);
    msb_one = frame_top[15];
    crc_bad = cfg_crc_en_s && !bad_len && (frame_len >= `LEN_20) &&
              (crc4(frame_top) != frame_crc);
    // Edges within the window after the rise reach the counter in time
    early_stray = (stray_now != stray_start_reg);
    frame_err = bad_len || msb_one || desel_err_reg || early_stray;
    accept = !bad_len && !msb_one && !crc_bad && !early_stray;
    rd_word = {mem_reg[{frame_top[13:9], 1'b0}],
               mem_reg[{frame_top[13:9], 1'b1}]};
    if (frame_top[13:9] == `NO_OP_PAIR) begin
      rd_word = 16'h0000;
    end else if (frame_top[13:9] == `WARN_PAIR) begin
      rd_word = {`WARN_FIXED, iflag_reg, crc_reg, 10'h000};
    end
  end

  always_comb begin
    state_next = state_reg;
    win_next = win_reg;
    sel_start_next = sel_start_reg;
    stray_start_next = stray_start_reg;
    stray_base_next = stray_base_reg;
    prev_len_next = prev_len_reg;
    desel_err_next = desel_err_reg;
    armed_next = armed_reg;
    resp_next = resp_reg;
    resp_crc_next = resp_crc_reg;
    base_sel_next = base_sel_reg;
    base_stray_next = base_stray_reg;
    corrupt_next = corrupt_reg;
    miso_oe_next = !cs_s;
    wr_done_next = 1'b0;
    rd_done_next = 1'b0;
    wr_en = 1'b0;
    wr_addr = frame_top[13:8];
    wr_data = frame_top[7:0];
    iflag_set = 1'b0;
    crc_set = 1'b0;
    case (state_reg)
      spi_frame_pkg::ST_IDLE: begin
        if (!cs_s) begin
          sel_start_next = sel_now;
          stray_start_next = stray_now;
          // Pulses seen while deselected make this frame count wrong
          desel_err_next = !armed_reg && stray_flag(prev_len_reg, cfg_frame17_s,
                                  stray_now - stray_base_reg);
          armed_next = 1'b0;
          state_next = spi_frame_pkg::ST_SELECTED;
        end else if (armed_reg && (stray_now != stray_base_reg)) begin
          // First bus traffic after power-up, seen while idle
          iflag_set = 1'b1;
          crc_set = cfg_crc_en_s;
          armed_next = 1'b0;
          stray_base_next = stray_now;
        end
      end
      spi_frame_pkg::ST_SELECTED: begin
        if (cs_s) begin
          win_next = 3'h0;
          state_next = spi_frame_pkg::ST_WINDOW;
        end
      end
      spi_frame_pkg::ST_WINDOW: begin
        win_next = win_reg + 3'h1;
        if (win_reg >= STRAY_WIN_LAST) begin
          state_next = spi_frame_pkg::ST_COMMIT;
        end
      end
      spi_frame_pkg::ST_COMMIT: begin
        iflag_set = frame_err;
        crc_set = crc_bad;
        if (accept) begin
          if (frame_top[14]) begin
            wr_en = 1'b1;
            wr_done_next = 1'b1;
          end else begin
            // A flagged but late-disturbed read still completes
            resp_next = rd_word;
            resp_crc_next = crc4(rd_word);
            rd_done_next = 1'b1;
          end
        end
        base_sel_next = sel_now;
        base_stray_next = stray_now;
        corrupt_next = (frame_len < `LEN_20);
        stray_base_next = stray_now;
        if (len_ok(frame_len, cfg_frame17_s)) begin
          prev_len_next = frame_len;
        end
        desel_err_next = 1'b0;
        state_next = spi_frame_pkg::ST_IDLE;
      end
      default: begin
        state_next = spi_frame_pkg::ST_IDLE;
      end
    endcase
    // Flags clear by writing one to them; a new event wins over the clear
    iflag_clr = wr_en && (wr_addr == `WARN_ADDR_HI) && wr_data[`IFLAG_BYTE_POS];
    crc_clr = wr_en && (wr_addr == `WARN_ADDR_HI) && wr_data[`CRC_BYTE_POS];
    iflag_next = iflag_set || (iflag_reg && !iflag_clr);
    crc_next = crc_set || (crc_reg && !crc_clr);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_reg <= spi_frame_pkg::ST_IDLE;
      win_reg <= 3'h0;
      sel_start_reg <= 6'h00;
      stray_start_reg <= 6'h00;
      stray_base_reg <= 6'h00;
      prev_len_reg <= `LEN_16;
      desel_err_reg <= 1'b0;
      armed_reg <= 1'b1;
      iflag_reg <= 1'b0;
      crc_reg <= 1'b0;
      resp_reg <= `RESP_RESET;
      resp_crc_reg <= `CRC_SEED;
      base_sel_reg <= 6'h00;
      base_stray_reg <= 6'h00;
      corrupt_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
      wr_done_reg <= 1'b0;
      rd_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      win_reg <= win_next;
      sel_start_reg <= sel_start_next;
      stray_start_reg <= stray_start_next;
      stray_base_reg <= stray_base_next;
      prev_len_reg <= prev_len_next;
      desel_err_reg <= desel_err_next;
      armed_reg <= armed_next;
      iflag_reg <= iflag_next;
      crc_reg <= crc_next;
      resp_reg <= resp_next;
      resp_crc_reg <= resp_crc_next;
      base_sel_reg <= base_sel_next;
      base_stray_reg <= base_stray_next;
      corrupt_reg <= corrupt_next;
      miso_oe_reg <= miso_oe_next;
      wr_done_reg <= wr_done_next;
      rd_done_reg <= rd_done_next;
    end
  end

  // The no-op pair (addresses 0 and 1) and the warning pair are not backed by storage
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (wr_en && !is_hidden(wr_addr)) begin
      mem_next[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    for (int i = 0; i < 64; i++) begin
      if (i_sys_rst) begin
        mem_reg[i] <= `BYTE_RESET;
      end else begin
        mem_reg[i] <= mem_next[i];
      end
    end
  end

  assign lnk.tx_word = resp_reg;
  assign lnk.tx_crc = resp_crc_reg;
  assign lnk.base_sel = base_sel_reg;
  assign lnk.base_stray = base_stray_reg;
  assign lnk.corrupt = corrupt_reg;

  assign o_spi_miso_oe = miso_oe_reg;
  assign o_interface_error_flag = iflag_reg;
  assign o_crc_error_flag = crc_reg;
  assign o_write_done = wr_done_reg;
  assign o_read_done = rd_done_reg;

endmodule // spi_frame_error_detect

`default_nettype wire

// ==== verification/spi_frame_error_detect_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none

module spi_frame_error_detect_assertions (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic o_spi_miso_oe,
  input wire logic o_interface_error_flag,
  input wire logic o_crc_error_flag,
  input wire logic o_write_done,
  input wire logic o_read_done
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  property p_write_pulse;
    o_write_done |=> !o_write_done;
  endproperty
  a_write_pulse: assert property (p_write_pulse) else $error("write done too long");
  property p_read_pulse;
    o_read_done |=> !o_read_done;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read done too long");
  property p_done_exclusive;
    !(o_write_done && o_read_done);
  endproperty
  a_done_exclusive: assert property (p_done_exclusive) else $error("both done");
  // A frame is judged only once chip select has been high for a while
  property p_done_after_deselect;
    (o_write_done || o_read_done) |-> i_spi_cs_n && $past(i_spi_cs_n, 3);
  endproperty
  a_done_after_deselect: assert property (p_done_after_deselect) else $error("early done");
  property p_oe_off;
    i_spi_cs_n [*5] |-> !o_spi_miso_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("reply driven while deselected");
  property p_oe_on;
    !i_spi_cs_n [*5] |-> o_spi_miso_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("reply not driven while selected");
  property p_ier_clear;
    $fell(o_interface_error_flag) |-> o_write_done || $past(o_write_done);
  endproperty
  a_ier_clear: assert property (p_ier_clear) else $error("error flag fell without write");
  property p_crc_clear;
    $fell(o_crc_error_flag) |-> o_write_done || $past(o_write_done);
  endproperty
  a_crc_clear: assert property (p_crc_clear) else $error("crc flag fell without write");
  property p_flags_still;
    !i_spi_cs_n [*8] |-> $stable(o_interface_error_flag) && $stable(o_crc_error_flag);
  endproperty
  a_flags_still: assert property (p_flags_still) else $error("flag moved mid frame");

  c_ier_set: cover property ($rose(o_interface_error_flag));
  c_crc_set: cover property ($rose(o_crc_error_flag));
  c_write: cover property (o_write_done);
  c_read: cover property (o_read_done);
endmodule // spi_frame_error_detect_assertions

bind spi_frame_error_detect spi_frame_error_detect_assertions i_spi_frame_error_detect_assertions (
  .i_ref_clk, .i_sys_rst, .i_spi_sclk, .i_spi_cs_n, .o_spi_miso_oe,
  .o_interface_error_flag, .o_crc_error_flag, .o_write_done, .o_read_done
);

`default_nettype wire

// ==== verification/spi_master_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module spi_master_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  logic [20:0] rx;

  initial begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    rx = 21'h000000;
  end

  // Mode 3: data changes on the falling edge, reply taken before the rising one
  task automatic frame(input int n, input logic [20:0] bits);
    #7;
    rx = 21'h000000;
    o_cs_n = 1'b0;
    #40;
    for (int k = n - 1; k >= 0; k--) begin
      o_sclk = 1'b0;
      o_mosi = bits[k];
      #15;
      rx = {rx[19:0], i_miso};
      o_sclk = 1'b1;
      #15;
    end
    #20;
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // Released line must not keep showing the last bit
  endtask

  // Clock held high when deselected unless another device is being addressed
  task automatic stray(input int count);
    for (int k = 0; k < count; k++) begin
      o_sclk = 1'b0;
      #15;
      o_sclk = 1'b1;
      #15;
    end
  endtask
endmodule // spi_master_model

`default_nettype wire

// ==== verification/spi_frame_error_detect_test.sv ====
`timescale 1ns/100ps
`default_nettype none

module spi_frame_error_detect_test;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic seventeen_sel = 1'b0;
  logic crc_en = 1'b0;
  wire sclk;
  wire cs_n;
  wire mosi;
  logic miso, miso_oe, iface_err, crc_flag, wr_done, rd_done;
  int errors = 0;
  int num_checks = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;

  always #25 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (wr_done === 1'b1) wr_cnt <= wr_cnt + 1;
    if (rd_done === 1'b1) rd_cnt <= rd_cnt + 1;
  end

  spi_frame_error_detect i_spi_frame_error_detect (
    .i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
    .i_spi_mosi(mosi), .i_seventeen_bit_frame_select(seventeen_sel),
    .i_crc_check_enable(crc_en), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe),
    .o_interface_error_flag(iface_err), .o_crc_error_flag(crc_flag),
    .o_write_done(wr_done), .o_read_done(rd_done)
  );

  spi_master_model i_spi_master_model (
    .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso)
  );

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [3:0] crc4(input logic [15:0] v);
    logic [3:0] c;
    c = 4'hF;
    for (int i = 15; i >= 0; i--) begin
      c = {c[2:0], 1'b0} ^ ((c[3] ^ v[i]) ? 4'h3 : 4'h0);
    end
    return c;
  endfunction

  task automatic xfer(input int n, input logic wr, input logic [5:0] a, input logic [7:0] d);
    logic [15:0] c;
    logic [20:0] b;
    c = {1'b0, wr, a, d};
    case (n)
      20: b = {1'b0, c, crc4(c)};
      21: b = {c, crc4(c), 1'b0};
      default: b = {5'h00, c} << (n - 16);
    endcase
    @(negedge ref_clk);
    i_spi_master_model.frame(n, b);
    repeat (10) @(negedge ref_clk);
  endtask

  task automatic stray(input int k);
    i_spi_master_model.stray(k);
    repeat (10) @(negedge ref_clk);
  endtask

  // The reply to a read arrives on the following frame
  task automatic read21(input logic [5:0] a, input logic [15:0] exp);
    xfer(21, 1'b0, a, 8'h00);
    xfer(21, 1'b0, 6'h00, 8'h00);
    check_word(i_spi_master_model.rx[20:5], exp);
  endtask

  task automatic clear_flags();
    xfer(21, 1'b1, 6'h26, 8'h0C);
    check_flag(iface_err, 1'b0);
    check_flag(crc_flag, 1'b0);
  endtask

  task automatic test_power_on();
    check_flag(iface_err, 1'b0);
    stray(1);
    check_flag(iface_err, 1'b1);
    check_flag(crc_flag, 1'b1);
    clear_flags();
    $display("test power_on done");
  endtask

  task automatic test_read21();
    int n;
    int m;
    logic [3:0] c;
    n = wr_cnt;
    c = crc4(16'hA53C);
    xfer(21, 1'b1, 6'h10, 8'hA5);
    xfer(21, 1'b1, 6'h11, 8'h3C);
    check_word(16'(wr_cnt - n), 16'h0002);
    m = rd_cnt;
    read21(6'h10, 16'hA53C);
    check_word(16'(rd_cnt - m), 16'h0002);
    check_word({12'h000, i_spi_master_model.rx[4:1]}, {12'h000, c});
    check_flag(i_spi_master_model.rx[0], c[3]);
    read21(6'h00, 16'h0000);
    stray(5);
    xfer(21, 1'b0, 6'h00, 8'h00);
    check_flag(iface_err, 1'b0);
    $display("test read21 done");
  endtask

  task automatic test_len16();
    xfer(16, 1'b0, 6'h00, 8'h00);
    check_flag(iface_err, 1'b0);
    stray(1);
    xfer(16, 1'b0, 6'h00, 8'h00);
    check_flag(iface_err, 1'b1);
    read21(6'h26, 16'hB800);
    clear_flags();
    $display("test len16 done");
  endtask

  task automatic test_select();
    seventeen_sel = 1'b1;
    xfer(16, 1'b0, 6'h00, 8'h00);
    stray(2);
    xfer(16, 1'b0, 6'h00, 8'h00);
    check_flag(iface_err, 1'b1);
    clear_flags();
    xfer(17, 1'b0, 6'h00, 8'h00);
    stray(1);
    xfer(17, 1'b0, 6'h00, 8'h00);
    check_flag(iface_err, 1'b1);
    clear_flags();
    seventeen_sel = 1'b0;
    $display("test select done");
  endtask

  task automatic test_bad_frames();
    int n;
    n = wr_cnt;
    xfer(18, 1'b1, 6'h10, 8'hFF);
    check_flag(iface_err, 1'b1);
    check_word(16'(wr_cnt - n), 16'h0000);
    clear_flags();
    i_spi_master_model.frame(21, 21'h100000);
    repeat (10) @(negedge ref_clk);
    check_flag(iface_err, 1'b1);
    clear_flags();
    $display("test bad_frames done");
  endtask

  task automatic test_late20();
    int n;
    n = wr_cnt;
    xfer(20, 1'b1, 6'h12, 8'h5A);
    stray(1);
    xfer(20, 1'b0, 6'h10, 8'h00);
    check_flag(iface_err, 1'b1);
    check_word(16'(wr_cnt - n), 16'h0001);
    xfer(20, 1'b0, 6'h00, 8'h00);
    check_word(i_spi_master_model.rx[19:4], 16'hA53C);
    clear_flags();
    $display("test late20 done");
  endtask

  // A stray right at the chip select rise drops the read in flight
  task automatic test_early();
    int m;
    xfer(20, 1'b0, 6'h12, 8'h00);
    m = rd_cnt;
    @(negedge ref_clk);
    i_spi_master_model.frame(20, {1'b0, 16'h1000, crc4(16'h1000)});
    i_spi_master_model.stray(1);
    repeat (10) @(negedge ref_clk);
    check_word(16'(rd_cnt - m), 16'h0000);
    check_flag(iface_err, 1'b1);
    xfer(20, 1'b0, 6'h00, 8'h00);
    check_word(i_spi_master_model.rx[19:4], 16'h5A00);
    clear_flags();
    $display("test early done");
  endtask

  initial begin
    #5;
    // Link side needs a few clock edges to take the reset
    i_spi_master_model.stray(3);
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    // Two edges carry the release through the link's reset synchroniser
    i_spi_master_model.stray(2);
    crc_en = 1'b1;
    repeat (8) @(negedge ref_clk);
    test_power_on();
    test_read21();
    test_len16();
    test_select();
    test_bad_frames();
    test_late20();
    test_early();
    complete_run();
  end

  initial begin
    #1000000;
    errors++;
    complete_run();
  end
endmodule // spi_frame_error_detect_test

`default_nettype wire
